// ===== motor_bridge_pkg.sv
package motor_bridge_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS      = 10;
    localparam int STANDBY_TIME_US    = 1000;
    localparam int WAKE_TIME_US       = 30;
    localparam int CHOP_BLANK_NS      = 3600;
    localparam int TRIP_BLANK_NS      = 400;
    localparam int DEAD_TIME_NS       = 200;
    localparam int DEAD_TIME_MAX_NS   = 300;
    // Least times round up; longest times round down
    localparam int STANDBY_CYCLES     = (STANDBY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYCLES        = (WAKE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int CHOP_BLANK_CYCLES  = (CHOP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRIP_BLANK_CYCLES  = (TRIP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_CYCLES        = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFF_TIME_CYCLES    = 2000;
    localparam int CNT_W              = 20;
    // Reference attenuation of one tenth
    localparam int REF_DIV            = 10;
    localparam int LEVEL_W            = 12;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [4:0] {
        ST_STANDBY = 5'h01,
        ST_WAKE    = 5'h02,
        ST_CHARGE  = 5'h04,
        ST_FAST    = 5'h08,
        ST_SLOW    = 5'h10
    } phase_t;

    // Gate pattern order: high_a, high_b, low_a, low_b
    typedef logic [3:0] gates_t;
    localparam gates_t GATES_OFF = 4'h0;
endpackage

// ===== dead_time_leg.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// One bridge leg with break-before-make
// ----------------------------------------
module dead_time_leg
    import motor_bridge_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    // Requested gates
    input  wire logic want_high_i,
    input  wire logic want_low_i,
    // Applied gates
    output logic      high_o,
    output logic      low_o
);
    import motor_bridge_pkg::*;

    logic [7:0] dead_cnt;
    logic [7:0] gap_cnt;
    logic       req_on;
    logic       cur_on;
    wire        change = (want_high_i != high_o) || (want_low_i != low_o);
    wire        both_off = !high_o && !low_o;

    // Turn off first, wait dead time, then turn on
    // dead time insertion
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            high_o   <= 1'b0;
            low_o    <= 1'b0;
            dead_cnt <= 8'h00;
        end else if (change && !both_off) begin
            high_o   <= 1'b0;
            low_o    <= 1'b0;
            dead_cnt <= 8'(DEAD_CYCLES);
        end else if (change && dead_cnt > 8'h01) begin
            dead_cnt <= dead_cnt - 8'h01;
        end else if (change) begin
            high_o   <= want_high_i;
            low_o    <= want_low_i & ~want_high_i;
            dead_cnt <= 8'h00;
        end
    end

    assign req_on = want_high_i | want_low_i;
    assign cur_on = high_o | low_o;

    // Cycles the whole leg has stood off, saturating at the dead time
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gap_cnt <= 8'(DEAD_CYCLES);
        end else if (cur_on) begin
            gap_cnt <= 8'h00;
        end else if (gap_cnt < 8'(DEAD_CYCLES)) begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    a_leg_exclusive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !(high_o && low_o)) else $error("both switches of a leg on");

    a_leg_dead_gap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (req_on && $rose(cur_on)) |-> gap_cnt >= 8'(DEAD_CYCLES))
        else $error("dead time too short");
endmodule
`default_nettype wire

// ===== brushed_motor_bridge_control.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Decode inputs: forward, reverse, brake high-high.
// - Both low 1 ms enters standby, Hi-Z.
// - Either input high leaves standby.
// - Outputs drive just over 30 us after release.
// - Blank comparator 3.6 us after decay-to-charge.
// - Trip must persist 400 ns before accepted.
// - Every input edge restarts chop blanking.
// - Fixed off-time after trip sets ripple.
// - Off-time: half fast, half slow decay.
// - Zero current in fast decay: all off.
// - Phase switch patterns, mirrored for reverse.
// - Dead time on every leg switching.
// - Trip level is reference over ten.
// - Direct PWM follows input decode.
// - Overcurrent latches standby until standby release.
// - Thermal trip forces off, auto-resumes.
// - Undervoltage holds all switches off.
module brushed_motor_bridge_control
    import motor_bridge_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    // Host direction pins
    input  wire logic                 direction_input_a_i,
    input  wire logic                 direction_input_b_i,
    // Analog front end
    input  wire logic [LEVEL_W-1:0]   reference_level_i,
    input  wire logic [LEVEL_W-1:0]   sense_resistor_node_i,
    input  wire logic                 zero_current_i,
    input  wire logic                 overcurrent_i,
    input  wire logic                 thermal_trip_i,
    input  wire logic                 undervoltage_i,
    // Bridge gates
    output logic                      high_switch_a_o,
    output logic                      high_switch_b_o,
    output logic                      low_switch_a_o,
    output logic                      low_switch_b_o,
    // Status
    output logic                      standby_o,
    output logic                      overcurrent_latch_o
);
    import motor_bridge_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_zero;
    logic [2:0] sync_oc;
    logic [2:0] sync_th;
    logic [2:0] sync_uv;
    logic       dir_a;
    logic       dir_b;
    logic       zero_q;
    logic       oc_q;
    logic       th_q;
    logic       uv_q;

    // Three-stage chains; a change counts when stages two and three agree
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a    <= 3'h0;
            sync_b    <= 3'h0;
            sync_zero <= 3'h0;
            sync_oc   <= 3'h0;
            sync_th   <= 3'h0;
            sync_uv   <= 3'h0;
        end else begin
            sync_a    <= {sync_a[1:0], direction_input_a_i};
            sync_b    <= {sync_b[1:0], direction_input_b_i};
            sync_zero <= {sync_zero[1:0], zero_current_i};
            sync_oc   <= {sync_oc[1:0], overcurrent_i};
            sync_th   <= {sync_th[1:0], thermal_trip_i};
            sync_uv   <= {sync_uv[1:0], undervoltage_i};
        end
    end

    function automatic logic settle(input logic [2:0] s, input logic old);
        settle = (s[1] == s[2]) ? s[2] : old;
    endfunction

    // Qualified levels
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dir_a  <= 1'b0;
            dir_b  <= 1'b0;
            zero_q <= 1'b0;
            oc_q   <= 1'b0;
            th_q   <= 1'b0;
            uv_q   <= 1'b0;
        end else begin
            dir_a  <= settle(sync_a, dir_a);
            dir_b  <= settle(sync_b, dir_b);
            zero_q <= settle(sync_zero, zero_q);
            oc_q   <= settle(sync_oc, oc_q);
            th_q   <= settle(sync_th, th_q);
            uv_q   <= settle(sync_uv, uv_q);
        end
    end

    // ----------------------------------------
    // Decode and trip compare
    // ----------------------------------------
    logic dir_a_d;
    logic dir_b_d;
    wire  any_high   = dir_a | dir_b;
    wire  input_edge = (dir_a != dir_a_d) || (dir_b != dir_b_d);
    wire  brake      = dir_a & dir_b;
    wire  reverse    = ~dir_a & dir_b;
    wire [LEVEL_W+3:0] sense_x10 = (LEVEL_W+4)'(sense_resistor_node_i) * (LEVEL_W+4)'(REF_DIV);
    wire  trip_raw   = sense_x10 >= (LEVEL_W+4)'(reference_level_i);

    // ----------------------------------------
    // Phase sequencer
    // ----------------------------------------
    phase_t     phase;
    phase_t     next_phase;
    logic [CNT_W-1:0] idle_cnt;
    logic [CNT_W-1:0] phase_cnt;
    logic [CNT_W-1:0] blank_cnt;
    logic [7:0] trip_cnt;
    logic       oc_latch;
    logic       standby_q;
    wire        idle_done = idle_cnt >= CNT_W'(STANDBY_CYCLES);
    wire        blanked   = blank_cnt != '0;
    wire        trip_ok   = trip_cnt >= 8'(TRIP_BLANK_CYCLES);
    // Each decay phase counts from zero, so each compares with its own half
    wire        half_off  = phase_cnt >= CNT_W'(OFF_TIME_CYCLES / 2 - 1);
    wire        off_done  = phase_cnt >= CNT_W'(OFF_TIME_CYCLES - OFF_TIME_CYCLES / 2 - 1);
    wire        wake_done = phase_cnt >= CNT_W'(WAKE_CYCLES - 1);

    // Next phase selection
    always_comb begin
        next_phase = phase;
        unique case (phase)
            ST_STANDBY: if (any_high) next_phase = ST_WAKE;
            ST_WAKE:    if (wake_done) next_phase = ST_CHARGE;
            ST_CHARGE:  if (!blanked && trip_ok && !brake) next_phase = ST_FAST;
            ST_FAST:    if (half_off) next_phase = ST_SLOW;
            ST_SLOW:    if (off_done) next_phase = ST_CHARGE;
            default:    next_phase = ST_STANDBY;
        endcase
        if (idle_done || oc_latch) next_phase = ST_STANDBY;
        // latch released by idle then input
        if (phase == ST_STANDBY && !any_high) next_phase = ST_STANDBY;
    end

    // Phase register and counters
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            phase     <= ST_STANDBY;
            phase_cnt <= '0;
        end else begin
            phase     <= next_phase;
            phase_cnt <= (next_phase != phase) ? '0 : phase_cnt + 1'b1;
        end
    end

    // Idle counter, input history and blanking
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            idle_cnt  <= '0;
            dir_a_d   <= 1'b0;
            dir_b_d   <= 1'b0;
            blank_cnt <= '0;
            trip_cnt  <= 8'h00;
        end else begin
            dir_a_d  <= dir_a;
            dir_b_d  <= dir_b;
            idle_cnt <= any_high ? '0 : (idle_done ? idle_cnt : idle_cnt + 1'b1);
            if (input_edge || (next_phase == ST_CHARGE && phase != ST_CHARGE))
                blank_cnt <= CNT_W'(CHOP_BLANK_CYCLES);
            else if (blanked)
                blank_cnt <= blank_cnt - 1'b1;
            trip_cnt <= (trip_raw && phase == ST_CHARGE) ? (trip_ok ? trip_cnt : trip_cnt + 8'h01)
                                                         : 8'h00;
        end
    end

    // Overcurrent latch; clears once the inputs have stood low a full idle
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            oc_latch  <= 1'b0;
            standby_q <= 1'b1;
        end else begin
            standby_q <= next_phase == ST_STANDBY;
            if (oc_q)
                oc_latch <= 1'b1;
            else if (idle_done)
                oc_latch <= 1'b0;
        end
    end

    // ----------------------------------------
    // Gate pattern
    // ----------------------------------------
    wire   force_off = th_q | uv_q | oc_q | oc_latch;
    wire   running   = phase == ST_CHARGE || phase == ST_FAST || phase == ST_SLOW;
    gates_t fwd_pat;
    gates_t want;

    assign fwd_pat = (phase == ST_CHARGE) ? 4'h9 :
                     (phase == ST_FAST)   ? (zero_q ? GATES_OFF : 4'h6) :
                                            4'h3;
    // decode direction inputs, mirror for reverse
    assign want = (force_off || !running || !any_high) ? GATES_OFF :
                  brake   ? 4'h3 :
                  reverse ? {fwd_pat[2], fwd_pat[3], fwd_pat[0], fwd_pat[1]} :
                            fwd_pat;

    // Legs with dead time
    dead_time_leg u_leg_a (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .want_high_i (want[3]),
        .want_low_i  (want[1]),
        .high_o      (high_switch_a_o),
        .low_o       (low_switch_a_o)
    );
    dead_time_leg u_leg_b (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .want_high_i (want[2]),
        .want_low_i  (want[0]),
        .high_o      (high_switch_b_o),
        .low_o       (low_switch_b_o)
    );

    assign standby_o           = standby_q;
    assign overcurrent_latch_o = oc_latch;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_fault_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (th_q || uv_q) |=> ##1 !(high_switch_a_o || high_switch_b_o)) else $error("fault not off");

    a_standby_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (phase == ST_STANDBY) |=> ##1 !(high_switch_a_o || low_switch_a_o)) else $error("standby drives");

    a_blank_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (phase == ST_CHARGE && blanked) |=> phase != ST_FAST) else $error("trip during blanking");

    // Cycles spent in wake so far, for the wake bound
    logic [CNT_W-1:0] wake_run;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wake_run <= '0;
        end else begin
            wake_run <= (phase == ST_WAKE) ? wake_run + 1'b1 : '0;
        end
    end

    a_wake_bound: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (phase == ST_WAKE) |-> wake_run < CNT_W'(WAKE_CYCLES))
        else $error("wake too long");

    a_edge_blank: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        input_edge |=> blank_cnt == CNT_W'(CHOP_BLANK_CYCLES)) else $error("edge did not blank");

    a_fast_first: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (phase == ST_CHARGE && next_phase == ST_FAST) |=> phase == ST_FAST) else $error("no fast");

    a_oc_latch: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        oc_q |=> oc_latch) else $error("overcurrent not latched");

    a_brake_lows: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (brake && running && !force_off) |-> want == 4'h3) else $error("brake pattern wrong");
endmodule
`default_nettype wire

// ===== host_direction_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_direction_model (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    // Requested mode, bit 1 for pin a and bit 0 for pin b
    input  wire logic [1:0] mode_i,
    // Direction pins
    output logic            direction_input_a_o,
    output logic            direction_input_b_o
);
    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    // Direct PWM levels
    // Pins move just after a rising edge, as a host timer output would
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            direction_input_a_o <= 1'b0;
            direction_input_b_o <= 1'b0;
        end else begin
            direction_input_a_o <= mode_i[1];
            direction_input_b_o <= mode_i[0];
        end
    end
endmodule
`default_nettype wire

// ===== test_brushed_motor_bridge_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_brushed_motor_bridge_control;
    import motor_bridge_pkg::*;
    logic               clk_sys_i;
    logic               rst_i;
    logic [1:0]         mode;
    logic               dir_a;
    logic               dir_b;
    logic [LEVEL_W-1:0] ref_lvl;
    logic [LEVEL_W-1:0] sense;
    logic               zero_cur;
    logic               over_cur;
    logic               therm;
    logic               under_v;
    logic               ha;
    logic               hb;
    logic               la;
    logic               lb;
    logic               standby;
    logic               oc_latch;
    gates_t             gates;
    int                 fail_count;
    int                 compares;
    int                 ref_int;
    int                 trip;
    int                 took;
    int                 took2;

    assign gates = {ha, hb, la, lb};

    // ----------------------------------------
    // Clock and design
    // ----------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    host_direction_model i_host_direction_model (
        .clk_sys_i           (clk_sys_i),
        .rst_i               (rst_i),
        .mode_i              (mode),
        .direction_input_a_o (dir_a),
        .direction_input_b_o (dir_b)
    );

    brushed_motor_bridge_control i_brushed_motor_bridge_control (
        .clk_sys_i             (clk_sys_i),
        .rst_i                 (rst_i),
        .direction_input_a_i   (dir_a),
        .direction_input_b_i   (dir_b),
        .reference_level_i     (ref_lvl),
        .sense_resistor_node_i (sense),
        .zero_current_i        (zero_cur),
        .overcurrent_i         (over_cur),
        .thermal_trip_i        (therm),
        .undervoltage_i        (under_v),
        .high_switch_a_o       (ha),
        .high_switch_b_o       (hb),
        .low_switch_a_o        (la),
        .low_switch_b_o        (lb),
        .standby_o             (standby),
        .overcurrent_latch_o   (oc_latch)
    );

    // ----------------------------------------
    // Model and compare tasks
    // ----------------------------------------
    // Gates for dir 0 stop, 1 fwd, 2 rev, 3 brake; ph 0 charge, 1 fast, 2 slow
    function automatic gates_t model_gates(input int dir, input int ph);
        if (dir == 0) return GATES_OFF;
        if (dir == 3 || ph == 2) return 4'h3;
        if ((ph == 0) == (dir == 1)) return 4'h9;
        return 4'h6;
    endfunction

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_span(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("[ERR] %0t span %h outside %h..%h", $time, got, lo, hi);
        end
    endtask

    // Polls on the falling edge, where registered gates have settled
    task automatic wait_gates(input gates_t exp, input int limit, output int n);
        n = 0;
        @(negedge clk_sys_i);
        while (gates !== exp && n < limit) begin
            @(negedge clk_sys_i);
            n++;
        end
        check_val(gates, exp);
    endtask

    task automatic drive(input logic [1:0] m, input int s);
        @(posedge clk_sys_i);
        mode  <= m;
        sense <= s[LEVEL_W-1:0];
    endtask

    task automatic conclude();
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        fail_count++;
        conclude();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        fail_count = 0;
        compares   = 0;
        rst_i      = 1'b1;
        mode       = 2'h0;
        ref_lvl    = '0;
        sense      = '0;
        zero_cur   = 1'b0;
        over_cur   = 1'b0;
        therm      = 1'b0;
        under_v    = 1'b0;
        void'($urandom(32'h004F));
        ref_int = 200 + ($urandom % 3800);
        trip    = (ref_int + 9) / 10;
        repeat (3) @(posedge clk_sys_i);
        rst_i   <= 1'b0;
        ref_lvl <= ref_int[LEVEL_W-1:0];
        @(negedge clk_sys_i);
        check_val(standby, 1'b1);
        check_val(gates, GATES_OFF);
        check_val(oc_latch, 1'b0);
        // Wake into forward charge, just under the trip level
        drive(2'b10, trip - 1);
        wait_gates(model_gates(1, 0), WAKE_CYCLES + 200, took);
        check_span(took, WAKE_CYCLES, WAKE_CYCLES + DEAD_CYCLES + 20);
        check_val(standby, 1'b0);
        repeat (600) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check_val(gates, model_gates(1, 0));
        // Trip at threshold: charge, dead band, fast, slow, charge
        drive(2'b10, trip);
        wait_gates(GATES_OFF, 200, took);
        wait_gates(model_gates(1, 1), 40, took);
        // The first off cycle was seen by the previous poll
        check_span(took + 1, DEAD_CYCLES, DEAD_TIME_MAX_NS / CLK_PERIOD_NS);
        drive(2'b10, 0);
        wait_gates(4'h2, OFF_TIME_CYCLES, took);
        check_span(took, OFF_TIME_CYCLES / 2 - 30, OFF_TIME_CYCLES / 2 + 5);
        wait_gates(model_gates(1, 2), 40, took);
        check_span(took + 1, DEAD_CYCLES, DEAD_TIME_MAX_NS / CLK_PERIOD_NS);
        wait_gates(4'h1, OFF_TIME_CYCLES, took);
        check_span(took, OFF_TIME_CYCLES / 2 - 30, OFF_TIME_CYCLES / 2 + 5);
        // Trip held from charge entry is blanked
        drive(2'b10, trip);
        wait_gates(model_gates(1, 0), 40, took);
        wait_gates(GATES_OFF, 700, took2);
        check_span(took + took2, CHOP_BLANK_CYCLES - 5, CHOP_BLANK_CYCLES + 100);
        drive(2'b10, 0);
        wait_gates(model_gates(1, 1), 40, took);
        @(posedge clk_sys_i);
        zero_cur <= 1'b1;
        wait_gates(GATES_OFF, 20, took);
        @(posedge clk_sys_i);
        zero_cur <= 1'b0;
        wait_gates(model_gates(1, 0), OFF_TIME_CYCLES + 100, took);
        // Short pulse below persistence time does not trip
        repeat (400) @(posedge clk_sys_i);
        drive(2'b10, trip);
        repeat (TRIP_BLANK_CYCLES / 2) @(posedge clk_sys_i);
        drive(2'b10, 0);
        repeat (100) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check_val(gates, model_gates(1, 0));
        // Direct drive through every decode
        for (int d = 2; d <= 5; d++) begin
            drive(d[1:0], 0);
            // Mode bit 1 is pin a and bit 0 pin b; the model counts 1 fwd, 2 rev
            wait_gates(model_gates(int'({d[0], d[1]}), 0), 100, took);
            check_val(standby, 1'b0);
        end
        // Thermal and undervoltage force off, then resume
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys_i);
            therm   <= (k == 0);
            under_v <= (k == 1);
            wait_gates(GATES_OFF, 200, took);
            @(posedge clk_sys_i);
            therm   <= 1'b0;
            under_v <= 1'b0;
            // Reverse from the end of the decode loop is still requested
            wait_gates(model_gates(2, 0), 200, took);
        end
        // Overcurrent latches into standby
        @(posedge clk_sys_i);
        over_cur <= 1'b1;
        wait_gates(GATES_OFF, 200, took);
        @(posedge clk_sys_i);
        over_cur <= 1'b0;
        repeat (200) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check_val(gates, GATES_OFF);
        check_val(oc_latch, 1'b1);
        check_val(standby, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
